//--- verilog/serial_adc_sequencer_pkg.sv
/*
  Constants, states and carrier types for the serial converter sequencer.
  Assumes a 200 MHz system clock. All serial pins arrive asynchronously.
*/
package serial_adc_sequencer_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 5;
  localparam int CONV_TIME_NS   = 10000;                           // longest conversion time
  localparam int ABORT_TIME_NS  = 5000;                            // abort window after last clock
  localparam int CONV_CYCLES    = CONV_TIME_NS / CLK_PERIOD_NS;    // longest time rounds down
  localparam int STEP_CYCLES_I  = CONV_CYCLES / 12;                // one trial bit per step
  localparam int ABORT_CYCLES_I = ABORT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  STEP_CYCLES  = 8'(STEP_CYCLES_I);
  localparam logic [10:0] ABORT_CYCLES = 11'(ABORT_CYCLES_I);

  // ----------------------------------------
  // command register layout
  // ----------------------------------------
  localparam int CHANNEL_MSB            = 7;
  localparam int CHANNEL_LSB            = 4;
  localparam int LENGTH_CODE_HIGH_POS   = 3;
  localparam int LENGTH_CODE_LOW_POS    = 2;
  localparam int BIT_ORDER_SELECT_POS   = 1;
  localparam int SIGNED_OUTPUT_SELECT_POS = 0;
  localparam logic [7:0] CMD_RESET      = 8'h00;

  // select codes
  localparam logic [3:0] CODE_LAST_ANALOG = 4'ha;                  // analog_channel 0..10
  localparam logic [3:0] CODE_TEST_MID    = 4'hb;
  localparam logic [3:0] CODE_TEST_LOW    = 4'hc;
  localparam logic [3:0] CODE_TEST_HIGH   = 4'hd;
  localparam logic [3:0] CODE_POWER_DOWN  = 4'he;

  // cycle lengths and counts
  localparam logic [4:0] LEN_8        = 5'h08;
  localparam logic [4:0] LEN_12       = 5'h0c;
  localparam logic [4:0] LEN_16       = 5'h10;
  localparam logic [3:0] CMD_BITS     = 4'h8;
  localparam logic [4:0] SAMPLE_EDGE  = 5'h04;
  localparam logic [11:0] SAR_START   = 12'h800;
  localparam logic [11:0] SIGN_FLIP   = 12'h800;

  typedef enum logic [1:0] {IDLE, IO, CONV} phase_t;

  // converter-facing outputs grouped
  typedef struct packed {
    logic [3:0]  analogChannel;  // multiplexer select, test codes included
    logic        sampling;       // track while high, hold on fall
    logic        powerDown;      // software power-down
    logic [11:0] trialCode;      // successive-approximation trial word
  } analog_ctrl_t;

  // whole module state
  typedef struct packed {
    phase_t      phase;
    logic [2:0]  csSh;       // [0] meta, [1] sync, [2] previous
    logic [2:0]  ckSh;
    logic [1:0]  dinSh;
    logic [4:0]  edgeCnt;
    logic [3:0]  riseCnt;
    logic [7:0]  cmdShift;
    logic [7:0]  cmd;
    logic [7:0]  fmtCmd;     // format governing the next readout
    logic [15:0] outShift;
    logic [11:0] result;
    logic [3:0]  bitIdx;
    logic [7:0]  stepCnt;
    logic [10:0] convAge;
    logic        eoc;
    logic        dout;
    logic        doutEn;
    analog_ctrl_t ana;
  } state_t;

endpackage

//--- verilog/serial_adc_sequencer.sv
/*
  Serial command/readout and successive-approximation sequencer of a
  12-bit converter. Assumes an analog front end that follows the select
  code and sampling level and answers each trial word on cmpAbove,
  synchronous to clk. Chip select, serial clock and serial data are pins.
*/
`timescale 1ns/100ps

module serial_adc_sequencer
  import serial_adc_sequencer_pkg::*;
(
  input  wire logic         clk,          // 200 MHz system clock
  input  wire logic         sys_rst,      // async reset, active high
  input  wire logic         csN,          // chip select pin, active low
  input  wire logic         ioClk,        // serial clock pin
  input  wire logic         dataIn,       // serial command pin
  input  wire logic         cmpAbove,     // comparator: input above trial
  output logic              dataOut,      // serial result output
  output logic              dataOutEn,    // result pin driven when high
  output logic              convDone,     // high when no conversion runs
  output analog_ctrl_t      anaCtrl       // controls toward analog side
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // cycle length from a command byte
  function automatic logic [4:0] cycleLen(input logic [7:0] c);
    if (!c[LENGTH_CODE_LOW_POS]) begin
      cycleLen = LEN_12;
    end else if (c[LENGTH_CODE_HIGH_POS]) begin
      cycleLen = LEN_16;
    end else begin
      cycleLen = LEN_8;
    end
  endfunction

  // readout word, first bit at [15]
  function automatic logic [15:0] fmtWord(input logic [11:0] res, input logic [7:0] c);
    logic [15:0] w;
    logic [4:0]  len;
    int          k;
    w = {(c[SIGNED_OUTPUT_SELECT_POS] ? (res ^ SIGN_FLIP) : res), 4'h0};
    len = cycleLen(c);
    fmtWord = w;
    if (c[BIT_ORDER_SELECT_POS]) begin
      fmtWord = 16'h0000;
      for (int i = 0; i < 16; i++) begin
        if (i < int'(len)) begin
          k = 16 - int'(len) + i;
          fmtWord[15 - i] = w[k[3:0]];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  state_t s;
  state_t n;

  logic csHigh;
  logic csFall;
  logic ckRise;
  logic ckFall;
  logic lastFall;
  logic abortNow;
  logic stepEnd;

  // edge detection on synchronised pins
  assign csHigh   = s.csSh[1];
  assign csFall   = s.csSh[2] & ~s.csSh[1];
  assign ckRise   = ~s.ckSh[2] & s.ckSh[1];
  assign ckFall   = s.ckSh[2] & ~s.ckSh[1];
  assign lastFall = (s.phase == IO) & ~csHigh & ckFall & (s.edgeCnt + 5'h01 == cycleLen(s.fmtCmd));
  assign abortNow = (s.phase == CONV) & csFall & (s.convAge < ABORT_CYCLES);
  assign stepEnd  = (s.phase == CONV) & (s.stepCnt == STEP_CYCLES - 8'h01);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = s;
    // pins: two flops before any logic reads them
    n.csSh  = {s.csSh[1:0], csN};
    n.ckSh  = {s.ckSh[1:0], ioClk};
    n.dinSh = {s.dinSh[0], dataIn};

    // select high: pins ignored, output released
    if (csHigh) begin
      n.doutEn = 1'b0;
      n.ana.sampling = 1'b0;
      if (s.phase == IO) begin
        n.phase = IDLE;
      end
    end

    unique case (s.phase)
      IDLE, IO: begin
        if (csFall) begin
          // fresh I/O cycle with previous result on the pin
          n.phase    = IO;
          n.edgeCnt  = 5'h00;
          n.riseCnt  = 4'h0;
          n.outShift = fmtWord(s.result, s.fmtCmd);
          n.dout     = n.outShift[15];
          n.doutEn   = 1'b1;
        end else if (s.phase == IO && !csHigh) begin
          // command bits on the first eight rising edges only
          if (ckRise && s.riseCnt < CMD_BITS) begin
            n.cmdShift = {s.cmdShift[6:0], s.dinSh[1]};
            n.riseCnt  = s.riseCnt + 4'h1;
          end
          // falling edge: count, open sampling, shift readout
          if (ckFall) begin
            n.edgeCnt = s.edgeCnt + 5'h01;
            if (s.edgeCnt + 5'h01 == SAMPLE_EDGE) begin
              n.ana.analogChannel = s.cmdShift[3:0];
              n.ana.sampling      = 1'b1;
            end
            // cycle end: latch command, then power down or convert
            if (lastFall) begin
              n.cmd = s.cmdShift;
              n.ana.sampling = 1'b0;
              n.edgeCnt = 5'h00;
              n.riseCnt = 4'h0;
              if (s.cmdShift[CHANNEL_MSB:CHANNEL_LSB] == CODE_POWER_DOWN) begin
                // no conversion, ready for the next cycle
                n.ana.powerDown = 1'b1;
                n.outShift = fmtWord(s.result, s.fmtCmd);
                n.dout = n.outShift[15];
              end else begin
                n.ana.powerDown = 1'b0;
                n.fmtCmd  = s.cmdShift;
                n.phase   = CONV;
                n.eoc     = 1'b0;
                n.ana.trialCode = SAR_START;
                n.bitIdx  = 4'hb;
                n.stepCnt = 8'h00;
                n.convAge = 11'h000;
              end
            end else begin
              n.outShift = {s.outShift[14:0], 1'b0};
              n.dout     = s.outShift[14];
            end
          end
        end
      end
      CONV: begin
        // age for the abort window, step timer
        if (s.convAge != 11'h7ff) begin
          n.convAge = s.convAge + 11'h001;
        end
        n.stepCnt = s.stepCnt + 8'h01;
        if (abortNow) begin
          // early select fall drops the conversion
          n.phase    = IO;
          n.eoc      = 1'b1;
          n.edgeCnt  = 5'h00;
          n.riseCnt  = 4'h0;
          n.outShift = fmtWord(s.result, s.fmtCmd);
          n.dout     = n.outShift[15];
          n.doutEn   = 1'b1;
        end else if (stepEnd) begin
          // decide current bit, try the next lower one
          n.stepCnt = 8'h00;
          if (!cmpAbove) begin
            n.ana.trialCode[s.bitIdx] = 1'b0;
          end
          if (s.bitIdx == 4'h0) begin
            n.result = n.ana.trialCode;
            n.eoc    = 1'b1;
            if (!csHigh) begin
              n.phase    = IO;
              n.edgeCnt  = 5'h00;
              n.riseCnt  = 4'h0;
              n.outShift = fmtWord(n.result, s.fmtCmd);
              n.dout     = n.outShift[15];
              n.doutEn   = 1'b1;
            end else begin
              n.phase = IDLE;
            end
          end else begin
            n.bitIdx = s.bitIdx - 4'h1;
            n.ana.trialCode[s.bitIdx - 4'h1] = 1'b1;
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // reset: done high, command cleared, output released
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{phase: IDLE, csSh: 3'h7, ckSh: 3'h0, dinSh: 2'h0,
             edgeCnt: 5'h00, riseCnt: 4'h0, cmdShift: CMD_RESET,
             cmd: CMD_RESET, fmtCmd: CMD_RESET, outShift: 16'h0000,
             result: 12'h000, bitIdx: 4'h0, stepCnt: 8'h00,
             convAge: 11'h000, eoc: 1'b1, dout: 1'b0, doutEn: 1'b0,
             ana: '{analogChannel: 4'h0, sampling: 1'b0,
                    powerDown: 1'b0, trialCode: 12'h000}};
    end else begin
      s <= n;
    end
  end

  // outputs straight from flops
  assign dataOut   = s.dout;
  assign dataOutEn = s.doutEn;
  assign convDone  = s.eoc;
  assign anaCtrl   = s.ana;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // reset and link framing
  // ----------------------------------------
  // done high and format cleared on release
  reset_state_a: assert property ($fell(sys_rst) |-> convDone && !dataOutEn && s.fmtCmd == CMD_RESET)
    else $error("state not cleared by reset");
  // output released while deselected
  out_release_a: assert property (csHigh |=> !dataOutEn)
    else $error("output driven while select high");
  // output stays driven while selected
  en_hold_a: assert property (dataOutEn && !csHigh |=> dataOutEn)
    else $error("output released while selected");
  // select fall restarts the counters
  fresh_cycle_a: assert property (csFall && s.phase != CONV |=>
                                  s.phase == IO && s.edgeCnt == 5'h00 && s.riseCnt == 4'h0)
    else $error("select fall did not start a fresh cycle");
  // first bit at select fall
  first_bit_a: assert property (csFall && s.phase != CONV |=> dataOutEn && dataOut == s.outShift[15])
    else $error("first bit missing after select fall");
  // first bit at conversion done
  done_bit_a: assert property ($rose(convDone) && !csHigh |-> dataOutEn && dataOut == s.outShift[15])
    else $error("first bit missing at conversion done");
  // each later bit on a serial falling edge
  shift_out_a: assert property (s.phase == IO && !csHigh && !csFall && ckFall && !lastFall |=>
                                dataOut == $past(s.outShift[14]))
    else $error("readout bit not shifted on falling edge");
  // readout bit holds between falling edges
  dout_stable_a: assert property (s.phase == IO && !ckFall && !csFall |=> $stable(dataOut))
    else $error("readout bit changed between falling edges");
  // frame length bound
  edge_bound_a: assert property (s.edgeCnt < cycleLen(s.fmtCmd))
    else $error("cycle longer than selected length");
  // at most eight command bits
  cmd_bits_a: assert property (s.riseCnt <= CMD_BITS)
    else $error("more than eight command bits taken");
  // later rising edges leave the command alone
  cmd_ignore_a: assert property (ckRise && s.riseCnt == CMD_BITS |=> $stable(s.cmdShift))
    else $error("serial input taken after eight bits");

  // ----------------------------------------
  // conversion sequencing
  // ----------------------------------------
  // conversion begins at cycle end
  cycle_end_a: assert property (lastFall && s.cmdShift[7:4] != CODE_POWER_DOWN |=> s.phase == CONV && !convDone)
    else $error("conversion not started at cycle end");
  // done falls only right after cycle end
  conv_start_a: assert property ($fell(convDone) |-> $past(lastFall))
    else $error("conversion started outside cycle end");
  // conversion bounded by its age counter
  conv_time_a: assert property (!convDone |-> s.convAge < 11'(CONV_CYCLES))
    else $error("conversion exceeded its time");
  // done low only while converting
  done_low_a: assert property (!convDone |-> s.phase == CONV)
    else $error("done low outside conversion");
  // first trial word is mid-scale
  trial_start_a: assert property (lastFall && !csFall && s.cmdShift[7:4] != CODE_POWER_DOWN |=>
                                  anaCtrl.trialCode == SAR_START)
    else $error("first trial word wrong");
  // next lower bit tried after each step
  sar_step_a: assert property (stepEnd && !abortNow && s.bitIdx != 4'h0 |=>
                               s.bitIdx == $past(s.bitIdx) - 4'h1 && anaCtrl.trialCode[s.bitIdx])
    else $error("trial bit sequence broken");
  // result latched as done rises
  result_latch_a: assert property (stepEnd && !abortNow && s.bitIdx == 4'h0 |=>
                                   convDone && s.result == anaCtrl.trialCode)
    else $error("result not latched at conversion end");
  // early select fall aborts and restarts readout
  abort_a: assert property (abortNow |=> convDone && dataOutEn && s.phase == IO)
    else $error("abort did not restart the cycle");

  // ----------------------------------------
  // sampling and select codes
  // ----------------------------------------
  // sampling opens at fourth falling edge
  sample_start_a: assert property (s.phase == IO && !csHigh && ckFall && s.edgeCnt == 5'h03 |=> anaCtrl.sampling)
    else $error("sampling did not start at fourth edge");
  // select code applied at sampling start
  channel_latch_a: assert property (s.phase == IO && !csHigh && !csFall && ckFall && s.edgeCnt == 5'h03 |=>
                                    anaCtrl.analogChannel == $past(s.cmdShift[3:0]))
    else $error("select code not applied");
  // sample held at last falling edge
  sample_hold_a: assert property (lastFall && !csFall |=> !anaCtrl.sampling)
    else $error("sample not held at cycle end");
  // power-down code skips conversion
  power_down_a: assert property (lastFall && s.cmdShift[7:4] == CODE_POWER_DOWN |=> anaCtrl.powerDown && convDone)
    else $error("power-down code not honoured");
  // no conversion while powered down
  pd_done_a: assert property (anaCtrl.powerDown |-> convDone)
    else $error("conversion running in power-down");

  // ----------------------------------------
  // scenario covers
  // ----------------------------------------
  // readout straight after a held-select conversion
  conv_done_c: cover property ($rose(convDone) && !csHigh);
  // select fall early in a conversion
  abort_c:     cover property (abortNow);
  // least significant bit first selected
  lsb_first_c: cover property (lastFall && s.cmdShift[BIT_ORDER_SELECT_POS]);
  // entry into power-down
  pd_c:        cover property ($rose(anaCtrl.powerDown));
  // sixteen-clock frame completed
  len16_c:     cover property (lastFall && s.fmtCmd[LENGTH_CODE_HIGH_POS] && s.fmtCmd[LENGTH_CODE_LOW_POS]);

endmodule // serial_adc_sequencer

//--- tb/serial_host_model.sv
/*
  Host serial port model: select, serial clock and command bits, result capture.
  Assumes the bench calls its tasks and that clk runs at 200 MHz.
*/
`timescale 1ns/100ps

module serial_host_model (
  input  wire logic clk,      // system clock, paces the link
  input  wire logic dataOut,  // result bit from the device
  output logic      csN,      // select, active low
  output logic      ioClk,    // serial clock, 80 ns period
  output logic      dataIn    // command bit
);
  // ----------------------------------------
  // link driver
  // ----------------------------------------
  // idle levels; serial clock stands still between frames
  initial begin
    csN = 1'b1;
    ioClk = 1'b0;
    dataIn = 1'b0;
  end

  // wait whole system clocks and land just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // select falls: fresh frame; setup of eight clocks before any edge
  task automatic csLow();
    csN = 1'b0;
    step(8);
  endtask

  // select rises: device lets go of the link
  task automatic csHigh();
    csN = 1'b1;
    step(8);
  endtask

  // one frame of n serial clocks, command msb first, result taken at rising edges
  task automatic xfer(input logic [7:0] cmd, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    if (csN) begin
      csLow();
    end
    for (int k = 0; k < n; k++) begin
      dataIn = (k < 8) ? cmd[7-k] : ~dataIn;
      step(8);
      ioClk = 1'b1;
      rd = {rd[14:0], dataOut};
      step(8);
      ioClk = 1'b0;
    end
    dataIn = ~dataIn;  // line no longer meaningful after the frame
  endtask
endmodule  // serial_host_model

//--- tb/serial_adc_sequencer_bench.sv
/*
  Self-checking bench for the serial converter sequencer.
  Assumes the host model drives the link and an ideal analog side answers trials.
*/
`timescale 1ns/100ps

module serial_adc_sequencer_bench;
  import serial_adc_sequencer_pkg::*;

  logic         clk = 1'b0;       // 200 MHz
  logic         sys_rst;          // held for 8 clocks
  logic         cmpAbove;         // analog answer
  logic         csN;              // select from host
  logic         ioClk;            // serial clock from host
  logic         dataIn;           // command bit from host
  logic         dataOut;          // result bit
  logic         dataOutEn;        // result pin driven
  logic         dataLine;         // result pin as the host sees it
  logic         convDone;         // conversion done
  analog_ctrl_t anaCtrl;          // analog controls
  logic [11:0]  level [16];       // input level per select code
  logic [15:0]  rd;               // captured readout
  int           mismatches = 0;
  int           checks = 0;

  // ----------------------------------------
  // clock, analog side, instances
  // ----------------------------------------
  always #2.5 clk = ~clk;

  // ideal input half an lsb above its code, answered one clock late
  always @(posedge clk) cmpAbove <= level[anaCtrl.analogChannel] >= anaCtrl.trialCode;

  // released pin shows the inverse of the last bit
  assign dataLine = dataOutEn ? dataOut : ~dataOut;

  serial_adc_sequencer dut_u (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .csN       (csN),
    .ioClk     (ioClk),
    .dataIn    (dataIn),
    .cmpAbove  (cmpAbove),
    .dataOut   (dataOut),
    .dataOutEn (dataOutEn),
    .convDone  (convDone),
    .anaCtrl   (anaCtrl)
  );

  serial_host_model hostU (
    .clk     (clk),
    .dataOut (dataLine),
    .csN     (csN),
    .ioClk   (ioClk),
    .dataIn  (dataIn)
  );

  // ----------------------------------------
  // checking tasks
  // ----------------------------------------
  // compare one value, count it, report a mismatch
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // conversion after a frame: done low, code latched, done back within bound
  task automatic conv(input logic [3:0] chan);
    int i;
    hostU.step(8);
    chk(16'({anaCtrl.sampling, convDone}), 16'h0000);
    chk(16'(anaCtrl.analogChannel), 16'(chan));
    for (i = 0; i < 2400 && convDone !== 1'b1; i++) hostU.step(1);
    chk(16'(convDone), 16'h0001);
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  // main sequence
  initial begin
    sys_rst = 1'b1;
    for (int c = 0; c < 16; c++) level[c] = 12'h000;
    level[3] = 12'ha5c;
    level[11] = 12'h800;
    level[13] = 12'hfff;
    hostU.step(8);
    sys_rst = 1'b0;
    hostU.step(4);
    chk(16'(convDone), 16'h0001);
    chk(16'(dataOutEn), 16'h0000);
    chk(16'(anaCtrl.powerDown), 16'h0000);
    $display("test reset done");

    hostU.xfer(8'h30, 12, rd);
    conv(4'h3);
    chk(16'({dataOutEn, dataOut}), 16'h0003);
    hostU.xfer(8'hd4, 12, rd);
    chk(rd, 16'h0a5c);
    conv(4'hd);
    hostU.csHigh();
    chk(16'(dataOutEn), 16'h0000);
    $display("test held select done");

    hostU.xfer(8'hcf, 8, rd);
    chk(rd, 16'h00ff);
    conv(4'hc);
    hostU.csHigh();
    hostU.xfer(8'hb0, 16, rd);
    chk(rd, 16'h0001);
    conv(4'hb);
    hostU.csHigh();
    $display("test formats done");

    hostU.xfer(8'h30, 12, rd);
    chk(rd, 16'h0800);
    hostU.step(8);
    chk(16'(convDone), 16'h0000);
    hostU.csHigh();
    hostU.csLow();
    chk(16'(convDone), 16'h0001);
    hostU.xfer(8'he0, 12, rd);
    chk(rd, 16'h0800);
    hostU.step(8);
    chk(16'({anaCtrl.powerDown, convDone}), 16'h0003);
    $display("test abort and power-down done");

    hostU.csHigh();
    sys_rst = 1'b1;
    hostU.step(8);
    sys_rst = 1'b0;
    hostU.step(4);
    chk(16'({anaCtrl.powerDown, convDone, dataOutEn}), 16'h0002);
    hostU.xfer(8'h30, 12, rd);
    chk(rd, 16'h0000);
    conv(4'h3);
    hostU.csHigh();
    $display("test mid-run reset done");
    summarize();
  end

  // watchdog: tests need about 60 us
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
endmodule  // serial_adc_sequencer_bench
